// ==== core/twm_pkg.sv ====
// Purpose: Shared constants and types for the 8-bit waveform timer block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package twm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_PIN_DIR = 8'h1C;
  // Field positions
  localparam int CHA_HI = 7;
  localparam int CHA_LO = 6;
  localparam int CHB_HI = 5;
  localparam int CHB_LO = 4;
  localparam int WGM_HI_POS = 3;
  localparam logic [7:0] CTRL_A_RMASK = 8'hF3;
  localparam logic [7:0] CTRL_B_RMASK = 8'h08;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // Status bit positions
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMPA = 1;
  localparam int IRQ_CMPB = 2;
  // Output action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOG = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Decoded operating mode
  typedef enum logic [1:0] {
    TWM_NORMAL, TWM_CLEAR_ON_MATCH, TWM_FAST, TWM_PHASE
  } twm_kind_e;
  // Per-channel compare events handed to the output cell
  typedef struct packed {
    logic match;
    logic at_bottom;
    logic at_top;
    logic counting_up;
    logic cmp_is_top;
  } twm_evt_s;
endpackage

// ==== core/twm_chan.sv ====
// Purpose: One compare output channel of the waveform timer
// Assumes: Events arrive unqualified; the output flop gates them with clk_en and tick
// Notes: Channel B passes allow_toggle low so code 01 stays reserved
module twm_chan (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic [1:0] action,
  input wire twm_pkg::twm_kind_e kind,
  input wire logic allow_toggle,
  input wire twm_pkg::twm_evt_s evt,
  output logic wave_out,
  output logic connected
);
  logic wave_reg;
  logic wave_next;
  logic pwm_hi; // Action high bit selects PWM set/clear behaviour
  logic inv; // Inverting polarity
  logic tog_ok; // Toggle code allowed in PWM modes
  logic special; // Compare equals TOP with action high bit set
  logic pwm_kind; // Counter runs one of the PWM sequences

  assign pwm_hi = action[1];
  assign inv = action[0];
  assign tog_ok = (action == twm_pkg::ACT_TOG) && allow_toggle;
  assign special = evt.cmp_is_top && pwm_hi;
  assign pwm_kind = (kind == twm_pkg::TWM_FAST) ||
    (kind == twm_pkg::TWM_PHASE);
  // Code 01 without toggle permission leaves the pin to the port in PWM
  assign connected = (action != twm_pkg::ACT_OFF) && // RULE1
    !(pwm_kind && action == twm_pkg::ACT_TOG && !allow_toggle); // RULE5 RULE6

  // Next output level by mode and action
  always_comb begin
    wave_next = wave_reg;
    case (kind)
      twm_pkg::TWM_NORMAL, twm_pkg::TWM_CLEAR_ON_MATCH: begin
        if (evt.match) begin // RULE3 RULE4
          case (action)
            twm_pkg::ACT_TOG: wave_next = ~wave_reg;
            twm_pkg::ACT_CLR: wave_next = 1'b0;
            twm_pkg::ACT_SET: wave_next = 1'b1;
            default: wave_next = wave_reg;
          endcase
        end
      end
      twm_pkg::TWM_FAST: begin
        if (pwm_hi) begin // RULE5 RULE6
          if (special) begin
            // Match ignored; level set at BOTTOM only
            // BOTTOM keeps its usual level, so the output stays flat
            if (evt.at_bottom) wave_next = ~inv; // RULE7
          end else if (evt.match) begin
            wave_next = inv;
          end else if (evt.at_bottom) begin
            wave_next = ~inv;
          end
        end else if (tog_ok && evt.match) begin
          wave_next = ~wave_reg;
        end
      end
      twm_pkg::TWM_PHASE: begin
        if (pwm_hi) begin // RULE8 RULE9
          if (special) begin
            // Match ignored; level settles at TOP
            if (evt.at_top) wave_next = ~inv; // RULE10
          end else if (evt.match) begin
            wave_next = evt.counting_up ? inv : ~inv;
          end
        end else if (tog_ok && evt.match) begin
          wave_next = ~wave_reg;
        end
      end
      default: wave_next = wave_reg;
    endcase
  end

  // Output flop, updated only on timer ticks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) wave_reg <= 1'b0;
    else if (clk_en && tick) wave_reg <= wave_next;
  end

  assign wave_out = wave_reg;
endmodule // twm_chan

// ==== core/twm_timer.sv ====
// Purpose: 8-bit timer with waveform mode control and two outputs
// Assumes: APB master keeps requests stable until pready
// Notes: Zero wait states; pready is always high
//
// Contract
// (RULE1) Nonzero action field connects compare output to pin
// (RULE2) Software sets pin direction before pin drives
// (RULE3) Channel A non-PWM: off, toggle, clear, set
// (RULE4) Channel B non-PWM decodes same as A
// (RULE5) Fast PWM A: clear/set, inverted, toggle if high
// (RULE6) Fast PWM B: clear/set, inverted, 01 reserved
// (RULE7) Fast PWM compare at TOP acts at BOTTOM
// (RULE8) Phase PWM A: up clears, down sets, toggles
// (RULE9) Phase PWM B: same, code 01 reserved
// (RULE10) Phase PWM compare at TOP acts at TOP
// (RULE11) Control bits 3:2 read as zero
// (RULE12) Three-bit mode from high bit and low bits
// (RULE13) TOP is 0xFF or compare A per mode
// (RULE14) Compare writes immediate or buffered to TOP
// (RULE15) Overflow flag at MAX, BOTTOM or TOP
// (RULE16) High mode bit is control B bit 3
// (RULE17) Fast PWM counts to TOP then clears
// (RULE18) Phase PWM counts up, down, holds TOP once
// (RULE19) Control register resets to zero
//
// Our own choices: the register offsets and the APB interface to the registers.
module twm_timer #(
  parameter int PRESCALE = 1 // Timer clock divider
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe,
  output logic irq
);
  // Registers
  // Every state element sits behind the single synchronous reset and
  // the clk_en freeze, so a frozen timer resumes exactly where it
  // stopped
  logic [7:0] ctrl_a_reg; // waveform_control_a
  logic [7:0] ctrl_b_reg; // waveform_control_b, only mode high bit kept
  logic [7:0] count_reg;
  logic [7:0] cmp_a_buf_reg; // Software-written compare A
  logic [7:0] cmp_b_buf_reg;
  logic [7:0] cmp_a_reg; // Active compare A
  logic [7:0] cmp_b_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic [1:0] dir_reg; // Pin direction bits
  logic up_reg; // Phase correct direction
  logic [15:0] pre_reg; // Prescaler count
  logic block_reg; // Match blocked after count write

  // Bus decode
  // Every access finishes in its first access cycle, so the decode is
  // purely combinational; an address off the map raises pslverr and
  // the write is dropped rather than aliased onto a real register
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic rd = acc && !pwrite;
  wire logic hit_ca = (paddr == twm_pkg::OFS_CTRL_A);
  wire logic hit_cb = (paddr == twm_pkg::OFS_CTRL_B);
  wire logic hit_cnt = (paddr == twm_pkg::OFS_COUNT);
  wire logic hit_oa = (paddr == twm_pkg::OFS_CMP_A);
  wire logic hit_ob = (paddr == twm_pkg::OFS_CMP_B);
  wire logic hit_st = (paddr == twm_pkg::OFS_IRQ_STAT);
  wire logic hit_mk = (paddr == twm_pkg::OFS_IRQ_MASK);
  wire logic hit_dir = (paddr == twm_pkg::OFS_PIN_DIR);
  wire logic hit_any = hit_ca | hit_cb | hit_cnt | hit_oa | hit_ob |
                       hit_st | hit_mk | hit_dir;

  // Mode decode
  // The three mode bits live in two registers; software that writes
  // them one at a time passes through an intermediate mode for one
  // bus transfer. Reserved modes 4 and 6 fall back to normal counting
  // so the outputs never hold a state that no table defines
  wire logic [2:0] wave_mode_select =
    {ctrl_b_reg[twm_pkg::WGM_HI_POS], ctrl_a_reg[1:0]}; // RULE12 RULE16
  wire logic wave_mode_high_bit = wave_mode_select[2];
  twm_pkg::twm_kind_e kind;
  always_comb begin
    case (wave_mode_select) // RULE12
      3'h1, 3'h5: kind = twm_pkg::TWM_PHASE;
      3'h2: kind = twm_pkg::TWM_CLEAR_ON_MATCH;
      3'h3, 3'h7: kind = twm_pkg::TWM_FAST;
      default: kind = twm_pkg::TWM_NORMAL; // Reserved 4, 6 run as normal
    endcase
  end
  wire logic top_is_cmp = (wave_mode_select == 3'h2) ||
    (wave_mode_select == 3'h5) || (wave_mode_select == 3'h7);
  wire logic [7:0] top_val =
    top_is_cmp ? cmp_a_reg : twm_pkg::CNT_MAX; // RULE13
  wire logic buffered = (kind == twm_pkg::TWM_FAST) ||
    (kind == twm_pkg::TWM_PHASE); // RULE14

  // Timer tick from prescaler
  // The divider runs only while clk_en is high; with PRESCALE of one
  // every enabled clock is a timer tick. A wider divider trades PWM
  // frequency for resolution of slow periods
  wire logic tick = (pre_reg == 16'(PRESCALE - 1));
  wire logic at_top = (count_reg == top_val);
  wire logic at_bot = (count_reg == twm_pkg::CNT_BOTTOM);
  wire logic at_max = (count_reg == twm_pkg::CNT_MAX);
  wire logic cnt_wr = wr && hit_cnt;

  // Next count per mode
  // Normal mode wraps through 0xFF by plain overflow of the adder.
  // Clear-on-match and fast PWM return to BOTTOM on the tick after TOP.
  // Phase correct turns round at TOP and at BOTTOM, so each end value
  // is shown for exactly one tick and the period is twice TOP
  logic [7:0] count_next;
  logic up_next;
  always_comb begin
    count_next = count_reg + 8'h01;
    up_next = up_reg;
    case (kind)
      twm_pkg::TWM_CLEAR_ON_MATCH, twm_pkg::TWM_FAST: begin
        if (at_top) count_next = twm_pkg::CNT_BOTTOM; // RULE17
      end
      twm_pkg::TWM_PHASE: begin // RULE18
        if (up_reg && at_top) begin
          up_next = 1'b0;
          count_next = count_reg - 8'h01;
        end else if (!up_reg && at_bot) begin
          up_next = 1'b1;
        end else if (!up_reg) begin
          count_next = count_reg - 8'h01;
        end
      end
      default: count_next = count_reg + 8'h01;
    endcase
  end

  // Overflow event per mode
  // The event is taken on a tick, so it marks the cycle in which the
  // counter shows MAX, BOTTOM or TOP; the flag itself rises one clock
  // later, together with the next count value
  logic ovf_evt;
  always_comb begin
    case (wave_mode_select) // RULE15
      3'h1, 3'h5: ovf_evt = at_bot && !up_reg;
      3'h7: ovf_evt = at_top;
      default: ovf_evt = at_max;
    endcase
  end

  // Compare events
  // A match is masked for one tick after a counter write. The BOTTOM
  // action of fast PWM is taken on the tick that leaves TOP, which is
  // the same tick that clears the counter
  wire logic m_a = (count_reg == cmp_a_reg) && !block_reg;
  wire logic m_b = (count_reg == cmp_b_reg) && !block_reg;
  twm_pkg::twm_evt_s evt_a;
  twm_pkg::twm_evt_s evt_b;
  // Fast PWM BOTTOM action fires on the TOP-to-BOTTOM step
  assign evt_a = '{match: m_a, at_bottom: at_top, at_top: at_top,
                   counting_up: up_reg, cmp_is_top: cmp_a_reg == top_val};
  assign evt_b = '{match: m_b, at_bottom: at_top, at_top: at_top,
                   counting_up: up_reg, cmp_is_top: cmp_b_reg == top_val};
  wire logic [2:0] evt_vec = {m_b, m_a, ovf_evt};

  // Control and compare registers
  // Writes land only while clk_en is high; a bus master that drops the
  // enable in mid transfer loses the write, which is the price of a
  // single freeze input. Reserved control bits are masked on entry so
  // the stored value and the read value never differ
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_a_reg <= twm_pkg::RST_CTRL; // RULE19
      ctrl_b_reg <= twm_pkg::RST_CTRL;
      mask_reg <= twm_pkg::RST_IRQ;
      dir_reg <= 2'h0;
      cmp_a_buf_reg <= twm_pkg::RST_BYTE;
      cmp_b_buf_reg <= twm_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (wr && hit_ca) ctrl_a_reg <= pwdata[7:0] & twm_pkg::CTRL_A_RMASK;
      if (wr && hit_cb) ctrl_b_reg <= pwdata[7:0] & twm_pkg::CTRL_B_RMASK;
      if (wr && hit_mk) mask_reg <= pwdata[2:0];
      if (wr && hit_dir) dir_reg <= pwdata[1:0];
      if (wr && hit_oa) cmp_a_buf_reg <= pwdata[7:0];
      if (wr && hit_ob) cmp_b_buf_reg <= pwdata[7:0];
    end
  end

  // Active compare values: immediate or loaded at TOP
  // In PWM modes the written value waits in the buffer until the tick
  // at TOP, so a new duty cycle never cuts a period short and no glitch
  // pulse reaches the pin. Non-PWM modes copy it on the next clock,
  // which a reader sees as immediate
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmp_a_reg <= twm_pkg::RST_BYTE;
      cmp_b_reg <= twm_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (!buffered || (tick && at_top)) begin // RULE14
        cmp_a_reg <= cmp_a_buf_reg;
        cmp_b_reg <= cmp_b_buf_reg;
      end
    end
  end

  // Counter, direction and prescaler
  // A software write to the counter wins over the tick of the same
  // clock and suppresses the compare match on the next tick; changing
  // the count while it runs can still step over a match, which users
  // must allow for
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= twm_pkg::RST_BYTE;
      up_reg <= 1'b1;
      pre_reg <= 16'h0000;
      block_reg <= 1'b0;
    end else if (clk_en) begin
      pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
      if (cnt_wr) begin
        // Software write blocks the next compare match
        count_reg <= pwdata[7:0];
        block_reg <= 1'b1;
      end else if (tick) begin
        count_reg <= count_next;
        up_reg <= up_next;
        block_reg <= 1'b0;
      end
    end
  end

  // Sticky status; a set in the same cycle as the read-clear wins
  // Only bits already captured in prdata are cleared, so an event
  // landing on the setup edge survives until the next read
  wire logic st_rd = rd && hit_st;
  wire logic [2:0] st_set = (clk_en && tick) ? evt_vec : 3'h0;
  wire logic [2:0] st_keep = st_rd ? (stat_reg & ~prdata[2:0]) : stat_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) stat_reg <= twm_pkg::RST_IRQ;
    else if (clk_en) stat_reg <= st_keep | st_set;
  end
  // Interrupt is a level, high while any unmasked status bit is set
  assign irq = |(stat_reg & mask_reg);

  // Output channels
  // Both channels share one cell; channel B refuses the toggle code in
  // PWM modes, so its code 01 stays reserved and leaves the pin to the
  // port logic. The pin enables also need the matching direction bit
  logic con_a;
  logic con_b;
  twm_chan u_chan_a (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .tick(tick),
    .action(ctrl_a_reg[twm_pkg::CHA_HI:twm_pkg::CHA_LO]), .kind(kind),
    .allow_toggle(wave_mode_high_bit), .evt(evt_a),
    .wave_out(compare_out_a), .connected(con_a)
  );
  twm_chan u_chan_b (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .tick(tick),
    .action(ctrl_a_reg[twm_pkg::CHB_HI:twm_pkg::CHB_LO]), .kind(kind),
    .allow_toggle(1'b0), .evt(evt_b),
    .wave_out(compare_out_b), .connected(con_b)
  );
  // Pin driven only when connected and direction is output
  assign compare_out_a_oe = con_a && dir_reg[0]; // RULE1 RULE2
  assign compare_out_b_oe = con_b && dir_reg[1]; // RULE1 RULE2

  // Read mux
  // Unmapped addresses read zero; the upper bits of each word are
  // always zero, since every register is one byte wide
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    if (hit_ca) rsel = ctrl_a_reg & twm_pkg::CTRL_A_RMASK; // RULE11
    if (hit_cb) rsel = ctrl_b_reg;
    if (hit_cnt) rsel = count_reg;
    if (hit_oa) rsel = cmp_a_buf_reg;
    if (hit_ob) rsel = cmp_b_buf_reg;
    if (hit_st) rsel = {5'h00, stat_reg};
    if (hit_mk) rsel = {5'h00, mask_reg};
    if (hit_dir) rsel = {6'h00, dir_reg};
  end

  // Read data latched during setup so it is a flop at access
  // Capturing in the setup cycle keeps prdata a flop output without
  // adding a wait state; the cost is that a value changing between
  // setup and access is returned as it stood at setup
  // pready is tied high and pslverr is decoded from the address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) prdata <= 32'h00000000;
    else if (clk_en && psel && !penable) prdata <= {24'h000000, rsel};
  end
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;
endmodule // twm_timer

// ==== tb/twm_pin_load.sv ====
// Purpose: Port pin with an external pull, fed by one compare output
// Assumes: Output enable high means the timer drives the pin
// Notes: The pull level differs per pin so a lost drive is visible
module twm_pin_load #(
  parameter logic PULL = 1'b1 // Level of the external pull resistor
) (
  input wire logic drv,
  input wire logic oe,
  output logic pin
);
  // Undriven pin settles to the pull, never to the last drive level
  assign pin = oe ? drv : PULL;
endmodule // twm_pin_load

// ==== tb/twm_monitor.sv ====
// Purpose: Port-level checks for the waveform timer
// Assumes: A write lands only in an access phase with clk_en high
// Notes: Shadows of control and direction predict enables; the mask shadow checks irq stays low while the mask is zero
module twm_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic compare_out_a,
  input wire logic compare_out_a_oe,
  input wire logic compare_out_b,
  input wire logic compare_out_b_oe,
  input wire logic irq
);
  logic [7:0] sh_ctrl; // Control A shadow
  logic sh_hi; // High mode bit shadow
  logic [1:0] sh_dir; // Pin direction shadow
  logic [2:0] sh_mask; // Interrupt mask shadow
  wire wr_ok = psel && penable && pwrite && clk_en; // Write that lands
  // Shadows follow only writes the design really takes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_ctrl <= 8'h00;
      sh_hi <= 1'b0;
      sh_dir <= 2'h0;
      sh_mask <= 3'h0;
    end else if (wr_ok) begin
      if (paddr == twm_pkg::OFS_CTRL_A) sh_ctrl <= pwdata[7:0];
      if (paddr == twm_pkg::OFS_CTRL_B) sh_hi <= pwdata[3];
      if (paddr == twm_pkg::OFS_PIN_DIR) sh_dir <= pwdata[1:0];
      if (paddr == twm_pkg::OFS_IRQ_MASK) sh_mask <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_acc ##0 (!pwrite && paddr == a);
  endsequence
  property p_ready;
    s_acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err;
    s_acc ##0 (paddr > 8'h1C) |-> pslverr && prdata == 32'h00000000;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access accepted");
  property p_ctrl;
    s_rd(twm_pkg::OFS_CTRL_A) |->
      prdata == {24'h000000, sh_ctrl & twm_pkg::CTRL_A_RMASK};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control A readback");
  property p_ctrlb;
    s_rd(twm_pkg::OFS_CTRL_B) |-> prdata == {28'h0000000, sh_hi, 3'h0};
  endproperty
  a_ctrlb: assert property (p_ctrlb) else $error("mode bit readback");
  // PWM modes (mode bit 0 set) disconnect code 01 without toggle right
  property p_oe_a;
    compare_out_a_oe == (sh_ctrl[7:6] != 2'h0 && sh_dir[0] &&
      !(sh_ctrl[0] && !sh_hi && sh_ctrl[7:6] == 2'h1));
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin A enable wrong");
  property p_oe_b;
    compare_out_b_oe == (sh_ctrl[5:4] != 2'h0 && sh_dir[1] &&
      !(sh_ctrl[0] && sh_ctrl[5:4] == 2'h1));
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B enable wrong");
  property p_frz;
    !clk_en |=> $stable(compare_out_a) && $stable(compare_out_b);
  endproperty
  a_frz: assert property (p_frz) else $error("output moved while frozen");
  property p_rst;
    disable iff (1'b0)
    sys_rst && clk_en |=> !compare_out_a && !compare_out_b && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not reset");
  property p_irq;
    sh_mask == 3'h0 |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("masked interrupt raised");
endmodule // twm_monitor

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the waveform timer
// Assumes: PRESCALE of 1, so the timer ticks on every enabled clock
// Notes: Waveforms are judged on the pins, so drive and pulls both count
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, clk_en, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, out_a, oe_a, out_b, oe_b, irq, pin_a, pin_b;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int k;
  twm_timer #(.PRESCALE(1)) u_twm_timer (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_out_a(out_a),
    .compare_out_a_oe(oe_a), .compare_out_b(out_b),
    .compare_out_b_oe(oe_b), .irq(irq));
  // Pull-up on A, pull-down on B
  twm_pin_load #(.PULL(1'b1)) u_pin_a (.drv(out_a), .oe(oe_a), .pin(pin_a));
  twm_pin_load #(.PULL(1'b0)) u_pin_b (.drv(out_b), .oe(oe_b), .pin(pin_b));
  // Free-running 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the longest sequence
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Cycles a pin spends high over a window
  task automatic hi(input int n, input logic ch);
    k = 0;
    repeat (n) begin
      @(posedge clk_sys);
      k += int'(ch ? pin_b : pin_a);
    end
  endtask
  // Cycles between two successive pin changes
  task automatic gap(input logic ch);
    logic l;
    l = ch ? pin_b : pin_a;
    while ((ch ? pin_b : pin_a) === l) @(posedge clk_sys);
    l = ~l;
    k = 0;
    while ((ch ? pin_b : pin_a) === l) begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  task automatic s_regs();
    apb(1'b0, twm_pkg::OFS_CTRL_A, 8'h00);
    chk("ctrl_a reset", rd, 32'h00000000);
    wr(twm_pkg::OFS_CTRL_A, 8'hFF);
    apb(1'b0, twm_pkg::OFS_CTRL_A, 8'h00);
    chk("ctrl_a reserved", rd, 32'h000000F3);
    wr(twm_pkg::OFS_CTRL_B, 8'hFF);
    apb(1'b0, twm_pkg::OFS_CTRL_B, 8'h00);
    chk("ctrl_b mode bit", rd, 32'h00000008);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped err", {31'h0, err}, 32'h00000001);
    wr(twm_pkg::OFS_CTRL_B, 8'h00);
    wr(twm_pkg::OFS_CTRL_A, 8'hA0);
    chk("pin a pulled", {31'h0, pin_a}, 32'h00000001);
    wr(twm_pkg::OFS_PIN_DIR, 8'h03);
    chk("pin a driven", {31'h0, pin_a}, 32'h00000000);
    chk("pin b enable", {31'h0, oe_b}, 32'h00000001);
    clk_en <= 1'b0;
    tick(6);
    clk_en <= 1'b1;
  endtask
  task automatic s_ctc();
    wr(twm_pkg::OFS_CMP_A, 8'h09);
    wr(twm_pkg::OFS_CMP_B, 8'h05);
    wr(twm_pkg::OFS_CTRL_A, 8'h52);
    wr(twm_pkg::OFS_COUNT, 8'h00);
    gap(1'b0);
    chk("ctc toggle a", 32'(k), 32'd10);
    gap(1'b1);
    chk("ctc toggle b", 32'(k), 32'd10);
    for (int c = 2; c < 4; c++) begin
      wr(twm_pkg::OFS_CTRL_A, {c[1:0], c[1:0], 4'h2});
      tick(30);
      chk("ctc level a", {31'h0, pin_a}, {31'h0, c[0]});
      chk("ctc level b", {31'h0, pin_b}, {31'h0, c[0]});
    end
    wr(twm_pkg::OFS_IRQ_MASK, 8'h01);
    apb(1'b0, twm_pkg::OFS_IRQ_STAT, 8'h00);
    tick(40);
    chk("no ovf in ctc", {31'h0, irq}, 32'h00000000);
    wr(twm_pkg::OFS_CTRL_A, 8'h02);
    chk("a off", {31'h0, oe_a}, 32'h00000000);
  endtask
  task automatic s_fast();
    wr(twm_pkg::OFS_CTRL_B, 8'h08);
    wr(twm_pkg::OFS_CTRL_A, 8'h73);
    tick(300);
    gap(1'b0);
    chk("mode7 toggle", 32'(k), 32'd10);
    hi(10, 1'b1);
    chk("mode7 inv b", 32'(k), 32'd4);
    chk("ovf at top", {31'h0, irq}, 32'h00000001);
    apb(1'b0, twm_pkg::OFS_IRQ_STAT, 8'h00);
    chk("ovf status", rd & 32'h1, 32'h00000001);
    wr(twm_pkg::OFS_IRQ_MASK, 8'h00);
    wr(twm_pkg::OFS_CTRL_B, 8'h00);
    chk("a01 off", {31'h0, oe_a}, 32'h00000000);
    wr(twm_pkg::OFS_CMP_A, 8'h40);
    wr(twm_pkg::OFS_CMP_B, 8'h10);
    wr(twm_pkg::OFS_CTRL_A, 8'hB3);
    tick(300);
    hi(256, 1'b0);
    chk("fast duty a", 32'(k), 32'd65);
    hi(256, 1'b1);
    chk("fast duty b", 32'(k), 32'd239);
    wr(twm_pkg::OFS_CMP_A, 8'hFF);
    tick(300);
    hi(256, 1'b0);
    chk("fast top a", 32'(k), 32'd256);
  endtask
  task automatic s_phase();
    wr(twm_pkg::OFS_CMP_A, 8'h40);
    wr(twm_pkg::OFS_CTRL_A, 8'hB1);
    tick(600);
    apb(1'b0, twm_pkg::OFS_IRQ_STAT, 8'h00);
    hi(510, 1'b0);
    chk("phase duty a", 32'(k), 32'd128);
    apb(1'b0, twm_pkg::OFS_IRQ_STAT, 8'h00);
    chk("ovf at bottom", rd & 32'h1, 32'h00000001);
    hi(510, 1'b1);
    chk("phase duty b", 32'(k), 32'd478);
    wr(twm_pkg::OFS_CMP_A, 8'hFF);
    tick(1100);
    hi(510, 1'b0);
    chk("phase top a", 32'(k), 32'd510);
  endtask
  // Reset for three cycles, then the scenarios in order
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    s_regs();
    s_ctc();
    s_fast();
    s_phase();
    stop_test();
  end
endmodule // tb
bind twm_timer twm_monitor u_twm_monitor (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .compare_out_a(compare_out_a),
  .compare_out_a_oe(compare_out_a_oe), .compare_out_b(compare_out_b),
  .compare_out_b_oe(compare_out_b_oe), .irq(irq));
